// File: common/csl_link_regs.svh
// Constants of the code segment call linkage block: low memory pointers,
// descriptor, label and status field positions.
// Assumes 16-bit memory words and 20-bit addresses made of a 4-bit bank and a 16-bit word.
`ifndef CSL_LINK_REGS_SVH
`define CSL_LINK_REGS_SVH

// ----------------------------------------------------------------------------
// Low memory pointers and table geometry
// ----------------------------------------------------------------------------
`define CSL_LOC_CST     16'h0000
`define CSL_LOC_PROGRAM_SEG_EXTENSION    16'h0001
`define CSL_TBL_BANK    4'h0
`define CSL_SEG_PROG    8'hC0
`define CSL_PROG_MAX    8'h3E
`define CSL_SEG_NONE    8'h00
`define CSL_DSEG_RSVD   8'h00
`define CSL_W_BANK      16'h0001
`define CSL_W_BASE      16'h0003
`define CSL_ONE         16'h0001
`define CSL_ENT0        7'h00
`define CSL_RST_WORD    16'h0000
`define CSL_STK_NEXT    20'h00001

// ----------------------------------------------------------------------------
// Descriptor first word and second word bank field
// ----------------------------------------------------------------------------
`define CSL_F_ABS       15
`define CSL_F_PRV       14
`define CSL_F_REF       13
`define CSL_F_TRC       12
`define CSL_LEN_R       11:0
`define CSL_BANK_R      3:0

// ----------------------------------------------------------------------------
// Labels, transfer length word and status word
// ----------------------------------------------------------------------------
`define CSL_L_EXT       0
`define CSL_L_UNC       15
`define CSL_L_OFF       14:1
`define CSL_L_SEG       15:8
`define CSL_L_STT       7:1
`define CSL_STT_LAST    7:0
`define CSL_ST_SEG      7:0
`define CSL_ST_PRV      15

`endif

// File: common/csl_link_pkg.sv
// Types of the code segment call linkage block.
// Assumes the constants header is included by the design file.
package csl_link_pkg;

    typedef enum logic [3:0] {
        CSL_IDLE   = 4'b0000,
        CSL_PUSH_R = 4'b0001,
        CSL_PUSH_S = 4'b0010,
        CSL_RD_LEN = 4'b0011,
        CSL_RD_ENT = 4'b0100,
        CSL_EVAL   = 4'b0101,
        CSL_SEG    = 4'b0110,
        CSL_RD_TBL = 4'b0111,
        CSL_RD_FIN = 4'b1000,
        CSL_RD_W1  = 4'b1001,
        CSL_WAIT_A = 4'b1010,
        CSL_WR_REF = 4'b1011,
        CSL_RD_W2  = 4'b1100,
        CSL_RD_W4  = 4'b1101,
        CSL_RD_TL  = 4'b1110,
        CSL_RD_TE  = 4'b1111
    } csl_state_type;

    typedef enum logic [2:0] {
        CSL_F_NONE   = 3'b000,
        CSL_F_SEG0   = 3'b001,
        CSL_F_SEGRNG = 3'b010,
        CSL_F_STTRNG = 3'b011,
        CSL_F_UNCALL = 3'b100,
        CSL_F_BADTGT = 3'b101
    } csl_fault_type;

    typedef struct packed {
        csl_state_type st;
        csl_fault_type fcode;
        logic          busy;
        logic          done;
        logic          fault;
        logic          mem_req;
        logic          mem_we;
        logic [19:0]   mem_addr;
        logic [15:0]   mem_wdata;
        logic [15:0]   base;
        logic [15:0]   limit;
        logic [15:0]   pc;
        logic [15:0]   status;
        logic [3:0]    bank;
        logic [15:0]   nbase;
        logic [15:0]   nlimit;
        logic [3:0]    nbank;
        logic [15:0]   desc;
        logic [15:0]   flags;
        logic [15:0]   label;
        logic [15:0]   ret;
        logic [15:0]   sstat;
        logic [7:0]    seg;
        logic [6:0]    ent;
        logic [6:0]    seg_transfer_table;
        logic          is_exit;
        logic          user;
        logic          prog;
        logic          absent_req;
        logic          trace;
        logic          dseg_fault;
    } csl_reg_type;

endpackage

// File: src/csl_link.sv
// Procedure call and exit linkage: segment lookup, descriptor decode,
// transfer table checks and loading of the code base and limit registers.
// Assumes one memory word port with a one-cycle ack, and stack logic outside
// that supplies the push address, the top-of-stack label and saved exit words.
//
// Function
// [R01] Segments below octal 300 use pointer at zero
// [R02] Octal 300 to 400 use pointer at one
// [R03] Program extension holds at most 63 segments
// [R04] Descriptor is four words: location and length
// [R05] Flags: absent, privileged, trace checked on call
// [R06] Length field is length over four, rescaled
// [R07] Every reference sets the descriptor reference flag
// [R08] Resident: bank and base; absent: disc address
// [R09] Code base loaded from descriptor fourth word
// [R10] Code limit computed from segment length
// [R11] Table entry zero points at final entry
// [R12] Transfer entry n fetched at limit minus n
// [R13] Entry zero is length; beyond last rejected
// [R14] Inside call to entry zero uses stack label
// [R15] External entry zero: check uncallable, start at base
// [R16] Label bit zero set means external label
// [R17] Local label is base-relative program counter offset
// [R18] Call pushes return address before transfer
// [R19] Absent target is brought in before transfer
// [R20] Uncallable entry refuses external user mode calls
// [R21] Exit restores status, base and return point
// [R22] Data segment zero is never allocated
`timescale 1ns/100ps
`include "csl_link_regs.svh"

module csl_link
    import csl_link_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Commands
    input  wire logic        call_req,
    input  wire logic [6:0]  call_entry,
    input  wire logic        user_mode,
    input  wire logic        exit_req,
    input  wire logic [15:0] saved_status,
    input  wire logic [15:0] saved_ret,
    // Stack side
    input  wire logic [19:0] stack_addr,
    input  wire logic [15:0] tos_label,
    // Segment loader
    input  wire logic        absent_done,
    // Data segment allocation check
    input  wire logic        dseg_req,
    input  wire logic [7:0]  dseg_num,
    // Memory port
    output logic             mem_req,
    output logic             mem_we,
    output logic [19:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    // Results
    output logic             busy,
    output logic             done,
    output logic             fault,
    output logic [2:0]       fault_code,
    output logic             absent_req,
    output logic [7:0]       absent_seg,
    output logic             trace_req,
    output logic             dseg_fault,
    output logic [15:0]      code_base_reg,
    output logic [15:0]      code_limit_reg,
    output logic [3:0]       code_bank,
    output logic [15:0]      prog_counter,
    output logic [15:0]      status_word
);

    csl_reg_type r_q;
    csl_reg_type r_d;
    logic        ack;
    logic [7:0]  prog_idx;
    logic [15:0] seg_off;
    logic [15:0] len_words;
    logic [15:0] lbl_off;
    logic [19:0] ent_addr;
    logic [19:0] tgt_addr;

    assign ack       = r_q.mem_req && mem_ack;
    assign prog_idx  = r_q.seg - `CSL_SEG_PROG; // see [R02]
    // Four words per descriptor, so the table index is scaled by four
    assign seg_off   = r_q.prog ? {6'h00, prog_idx, 2'b00} : {6'h00, r_q.seg, 2'b00}; // see [R04]
    // Length field counts groups of four words
    assign len_words = {2'b00, r_q.flags[`CSL_LEN_R], 2'b00}; // see [R06]
    assign lbl_off   = {2'b00, mem_rdata[`CSL_L_OFF]};
    // Transfer entries count backward from the limit
    assign ent_addr  = {r_q.bank, r_q.limit - {9'h000, r_q.ent}}; // see [R12]
    assign tgt_addr  = {r_q.nbank, r_q.nlimit - {9'h000, r_q.seg_transfer_table}}; // see [R12]

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic csl_reg_type go_mem(csl_reg_type s, csl_state_type nx,
                                           logic we, logic [19:0] a, logic [15:0] w);
        s.st        = nx;
        s.mem_req   = 1'b1;
        s.mem_we    = we;
        s.mem_addr  = a;
        s.mem_wdata = w;
        return s;
    endfunction

    function automatic csl_reg_type end_fault(csl_reg_type s, csl_fault_type f);
        s.st      = CSL_IDLE;
        s.busy    = 1'b0;
        s.fault   = 1'b1;
        s.fcode   = f;
        s.mem_req = 1'b0;
        return s;
    endfunction

    // Nothing current changes until every check on the target has passed
    function automatic csl_reg_type commit(csl_reg_type s, logic [15:0] new_pc);
        s.base    = s.nbase;
        s.limit   = s.nlimit;
        s.bank    = s.nbank;
        s.pc      = new_pc;
        s.status  = s.is_exit ? s.sstat : {s.flags[`CSL_F_PRV], 7'h00, s.seg};
        s.st      = CSL_IDLE;
        s.busy    = 1'b0;
        s.done    = 1'b1;
        s.mem_req = 1'b0;
        return s;
    endfunction

    // A local transfer keeps segment, limit and status as they are
    function automatic csl_reg_type finish_local(csl_reg_type s, logic [15:0] new_pc);
        s.pc      = new_pc;
        s.st      = CSL_IDLE;
        s.busy    = 1'b0;
        s.done    = 1'b1;
        s.mem_req = 1'b0;
        return s;
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        r_d            = r_q;
        r_d.done       = 1'b0;
        r_d.fault      = 1'b0;
        r_d.trace      = 1'b0;
        r_d.dseg_fault = dseg_req && (dseg_num == `CSL_DSEG_RSVD); // see [R22]
        if (ack)
        begin
            r_d.mem_req = 1'b0;
        end
        unique case (r_q.st)
            CSL_IDLE:
            begin
                if (call_req)
                begin
                    r_d.busy    = 1'b1;
                    r_d.is_exit = 1'b0;
                    r_d.ent     = call_entry;
                    r_d.user    = user_mode;
                    r_d         = go_mem(r_d, CSL_PUSH_R, 1'b1, stack_addr,
                                         r_q.pc - r_q.base + `CSL_ONE); // see [R18]
                end
                else if (exit_req)
                begin
                    r_d.busy    = 1'b1;
                    r_d.is_exit = 1'b1;
                    r_d.sstat   = saved_status;
                    r_d.ret     = saved_ret;
                    r_d.seg     = saved_status[`CSL_ST_SEG]; // see [R21]
                    r_d.st      = CSL_SEG;
                end
            end
            CSL_PUSH_R:
            begin
                if (ack)
                begin
                    r_d = go_mem(r_d, CSL_PUSH_S, 1'b1, stack_addr + `CSL_STK_NEXT, r_q.status);
                end
            end
            CSL_PUSH_S:
            begin
                if (ack && (r_q.ent == `CSL_ENT0))
                begin
                    // Entry zero from inside the segment takes its label off the stack
                    r_d.label = tos_label; // see [R14]
                    r_d.st    = CSL_EVAL;
                end
                else if (ack)
                begin
                    r_d = go_mem(r_d, CSL_RD_LEN, 1'b0, {r_q.bank, r_q.limit}, `CSL_RST_WORD); // see [R13]
                end
            end
            CSL_RD_LEN:
            begin
                if (ack && ({1'b0, r_q.ent} > mem_rdata[`CSL_STT_LAST]))
                begin
                    r_d = end_fault(r_d, CSL_F_STTRNG); // see [R13]
                end
                else if (ack)
                begin
                    r_d = go_mem(r_d, CSL_RD_ENT, 1'b0, ent_addr, `CSL_RST_WORD); // see [R12]
                end
            end
            CSL_RD_ENT:
            begin
                if (ack)
                begin
                    r_d.label = mem_rdata;
                    r_d.st    = CSL_EVAL;
                end
            end
            CSL_EVAL:
            begin
                if (r_q.label[`CSL_L_EXT])
                begin
                    r_d.seg = r_q.label[`CSL_L_SEG]; // see [R16]
                    r_d.seg_transfer_table = r_q.label[`CSL_L_STT];
                    r_d.st  = CSL_SEG;
                end
                else
                begin
                    r_d = finish_local(r_d, r_q.base + {2'b00, r_q.label[`CSL_L_OFF]}); // see [R17]
                end
            end
            CSL_SEG:
            begin
                r_d.prog = (r_q.seg >= `CSL_SEG_PROG);
                if (r_q.seg == `CSL_SEG_NONE)
                begin
                    // Entry zero is table control, never a segment
                    r_d = end_fault(r_d, CSL_F_SEG0); // see [R11]
                end
                else if ((r_q.seg >= `CSL_SEG_PROG) && (prog_idx > `CSL_PROG_MAX))
                begin
                    r_d = end_fault(r_d, CSL_F_SEGRNG); // see [R03]
                end
                else if (r_q.seg >= `CSL_SEG_PROG)
                begin
                    r_d = go_mem(r_d, CSL_RD_TBL, 1'b0, {`CSL_TBL_BANK, `CSL_LOC_PROGRAM_SEG_EXTENSION}, `CSL_RST_WORD); // see [R02]
                end
                else
                begin
                    r_d = go_mem(r_d, CSL_RD_TBL, 1'b0, {`CSL_TBL_BANK, `CSL_LOC_CST}, `CSL_RST_WORD); // see [R01]
                end
            end
            CSL_RD_TBL:
            begin
                if (ack)
                begin
                    r_d.desc = mem_rdata + seg_off;
                    if (r_q.prog)
                    begin
                        r_d = go_mem(r_d, CSL_RD_W1, 1'b0, {`CSL_TBL_BANK, mem_rdata + seg_off}, `CSL_RST_WORD);
                    end
                    else
                    begin
                        r_d = go_mem(r_d, CSL_RD_FIN, 1'b0, {`CSL_TBL_BANK, mem_rdata}, `CSL_RST_WORD); // see [R11]
                    end
                end
            end
            CSL_RD_FIN:
            begin
                // Entry zero holds the address of the last entry and so bounds the table
                if (ack && (r_q.desc > mem_rdata))
                begin
                    r_d = end_fault(r_d, CSL_F_SEGRNG); // see [R11]
                end
                else if (ack)
                begin
                    r_d = go_mem(r_d, CSL_RD_W1, 1'b0, {`CSL_TBL_BANK, r_q.desc}, `CSL_RST_WORD); // see [R04]
                end
            end
            CSL_RD_W1:
            begin
                if (ack)
                begin
                    r_d.flags = mem_rdata;
                    if (mem_rdata[`CSL_F_ABS])
                    begin
                        r_d.absent_req = 1'b1; // see [R05]
                        r_d.st         = CSL_WAIT_A;
                    end
                    else
                    begin
                        r_d.trace = mem_rdata[`CSL_F_TRC] && !r_q.is_exit; // see [R05]
                        r_d       = go_mem(r_d, CSL_WR_REF, 1'b1, {`CSL_TBL_BANK, r_q.desc},
                                           mem_rdata | (`CSL_ONE << `CSL_F_REF)); // see [R07]
                    end
                end
            end
            CSL_WAIT_A:
            begin
                // Words two and four hold a disc address while absent, so they are not read yet
                if (absent_done)
                begin
                    r_d.absent_req = 1'b0;
                    r_d            = go_mem(r_d, CSL_RD_W1, 1'b0, {`CSL_TBL_BANK, r_q.desc}, `CSL_RST_WORD); // see [R19]
                end
            end
            CSL_WR_REF:
            begin
                if (ack)
                begin
                    r_d = go_mem(r_d, CSL_RD_W2, 1'b0, {`CSL_TBL_BANK, r_q.desc + `CSL_W_BANK}, `CSL_RST_WORD);
                end
            end
            CSL_RD_W2:
            begin
                if (ack)
                begin
                    r_d.nbank = mem_rdata[`CSL_BANK_R]; // see [R08]
                    r_d       = go_mem(r_d, CSL_RD_W4, 1'b0, {`CSL_TBL_BANK, r_q.desc + `CSL_W_BASE}, `CSL_RST_WORD);
                end
            end
            CSL_RD_W4:
            begin
                if (ack)
                begin
                    r_d.nbase  = mem_rdata; // see [R09]
                    r_d.nlimit = mem_rdata + len_words - `CSL_ONE; // see [R10]
                    if (r_q.is_exit)
                    begin
                        r_d = commit(r_d, mem_rdata + r_q.ret); // see [R21]
                    end
                    else
                    begin
                        r_d = go_mem(r_d, CSL_RD_TL, 1'b0, {r_q.nbank, mem_rdata + len_words - `CSL_ONE},
                                     `CSL_RST_WORD);
                    end
                end
            end
            CSL_RD_TL:
            begin
                if (ack && (r_q.seg_transfer_table == `CSL_ENT0) && r_q.user && mem_rdata[`CSL_L_UNC])
                begin
                    r_d = end_fault(r_d, CSL_F_UNCALL); // see [R15]
                end
                else if (ack && (r_q.seg_transfer_table == `CSL_ENT0))
                begin
                    r_d = commit(r_d, r_q.nbase); // see [R15]
                end
                else if (ack && ({1'b0, r_q.seg_transfer_table} > mem_rdata[`CSL_STT_LAST]))
                begin
                    r_d = end_fault(r_d, CSL_F_STTRNG); // see [R13]
                end
                else if (ack)
                begin
                    r_d = go_mem(r_d, CSL_RD_TE, 1'b0, tgt_addr, `CSL_RST_WORD); // see [R12]
                end
            end
            CSL_RD_TE:
            begin
                // An external label found here would chain without end, so it is refused
                if (ack && mem_rdata[`CSL_L_EXT])
                begin
                    r_d = end_fault(r_d, CSL_F_BADTGT);
                end
                else if (ack && r_q.user && mem_rdata[`CSL_L_UNC])
                begin
                    r_d = end_fault(r_d, CSL_F_UNCALL); // see [R20]
                end
                else if (ack)
                begin
                    r_d = commit(r_d, r_q.nbase + lbl_off); // see [R17]
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q <= '0;
        end
        else if (ce)
        begin
            r_q <= r_d;
        end
    end

    assign mem_req        = r_q.mem_req;
    assign mem_we         = r_q.mem_we;
    assign mem_addr       = r_q.mem_addr;
    assign mem_wdata      = r_q.mem_wdata;
    assign busy           = r_q.busy;
    assign done           = r_q.done;
    assign fault          = r_q.fault;
    assign fault_code     = r_q.fcode;
    assign absent_req     = r_q.absent_req;
    assign absent_seg     = r_q.seg;
    assign trace_req      = r_q.trace;
    assign dseg_fault     = r_q.dseg_fault;
    assign code_base_reg  = r_q.base;
    assign code_limit_reg = r_q.limit;
    assign code_bank      = r_q.bank;
    assign prog_counter   = r_q.pc;
    assign status_word    = r_q.status;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_dseg_zero_flag: assert property (@(posedge clk) disable iff (!rst_n) // see [R22]
        ce && dseg_req && (dseg_num == `CSL_DSEG_RSVD) |=> dseg_fault)
    else
        $error("reserved data segment not flagged");

    a_push_return: assert property (@(posedge clk) disable iff (!rst_n) // see [R18]
        ce && (r_q.st == CSL_IDLE) && call_req |=> mem_req && mem_we && (mem_addr == $past(stack_addr)))
    else
        $error("call did not push the return address first");

    a_ref_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // see [R07]
        (r_q.st == CSL_WR_REF) && mem_req |-> mem_we && mem_wdata[`CSL_F_REF])
    else
        $error("descriptor written back without reference flag");

    a_stt_range: assert property (@(posedge clk) disable iff (!rst_n) // see [R13]
        ce && ack && (r_q.st == CSL_RD_LEN) && ({1'b0, r_q.ent} > mem_rdata[`CSL_STT_LAST])
        |=> fault && (fault_code == CSL_F_STTRNG))
    else
        $error("entry beyond table length not refused");

    a_uncall_user: assert property (@(posedge clk) disable iff (!rst_n) // see [R20]
        ce && ack && (r_q.st == CSL_RD_TE) && r_q.user && !mem_rdata[`CSL_L_EXT] && mem_rdata[`CSL_L_UNC]
        |=> fault && (fault_code == CSL_F_UNCALL))
    else
        $error("uncallable entry reached from user mode");

    a_absent_raise: assert property (@(posedge clk) disable iff (!rst_n) // see [R19]
        ce && ack && (r_q.st == CSL_RD_W1) && mem_rdata[`CSL_F_ABS]
        |=> absent_req && !done && (absent_seg == $past(r_q.seg)))
    else
        $error("absent segment not requested");

    a_exit_seg: assert property (@(posedge clk) disable iff (!rst_n) // see [R21]
        ce && (r_q.st == CSL_IDLE) && !call_req && exit_req
        |=> busy && (r_q.seg == $past(saved_status[`CSL_ST_SEG])))
    else
        $error("exit did not take the caller segment");

endmodule // csl_link

// File: test/csl_mem_model.sv
// Word memory on the far side of the linkage block; holds the tables.
// Assumes bank 0 only; the bench preloads mem by hierarchical access.
`timescale 1ns/100ps

module csl_mem_model
(
    // Clock, reset and wait state select
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    // Memory port
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [19:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata
);
    logic [15:0] mem [0:4095];
    logic [19:0] last_waddr;
    logic [1:0]  wait_q;

    // Read data is not held past the ack, so a late sample sees garbage
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_ack    <= 1'b0;
            mem_rdata  <= 16'h0000;
            wait_q     <= 2'h0;
            last_waddr <= 20'h00000;
        end
        else
        begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack && slow && wait_q < 2'h2)
                wait_q <= wait_q + 2'h1;
            else if (mem_req && !mem_ack)
            begin
                wait_q  <= 2'h0;
                mem_ack <= 1'b1;
                if (mem_we)
                begin
                    mem[mem_addr[11:0]] <= mem_wdata;
                    last_waddr          <= mem_addr;
                end
                else
                    mem_rdata <= mem[mem_addr[11:0]];
            end
        end
    end
endmodule // csl_mem_model

// File: test/code_segment_call_linkage_tb.sv
// Self-checking bench for the linkage block with a memory model.
// Assumes bank 0 tables; limit taken as base plus four times length minus one.
`timescale 1ns/100ps

module code_segment_call_linkage_tb;
    import csl_link_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, call_req = 0, user_mode = 0, exit_req = 0;
    logic absent_done = 0, dseg_req = 0, slow = 0, mem_ack, mem_req, mem_we;
    logic busy, done, fault, absent_req, trace_req, dseg_fault;
    logic [6:0] call_entry = 0;
    logic [7:0] dseg_num = 0, absent_seg, ab;
    logic [15:0] saved_status = 0, saved_ret = 0, tos_label = 0, mem_rdata, mem_wdata;
    logic [15:0] code_base_reg, code_limit_reg, prog_counter, status_word;
    logic [19:0] stack_addr = 20'h00800, mem_addr;
    logic [2:0] fault_code;
    logic [3:0] code_bank;
    int miscompares = 0, check_count = 0, seed = 32'h4a9737b2;

    always #5 clk = ~clk;
    csl_link DUT (.*);
    csl_mem_model mm (.*);

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    // Only the first absent request of a run is acknowledged, after the absent flag of the descriptor at 118 hex is cleared
    task automatic run(input logic ex, input logic [6:0] ent, input logic um);
        int n;
        n = 0;
        ab = 8'h00;
        @(posedge clk);
        call_entry <= ent;
        user_mode  <= um;
        stack_addr <= 20'h00800 + 20'($random(seed) & 254);
        if (ex)
            exit_req <= 1'b1;
        else
            call_req <= 1'b1;
        @(posedge clk);
        call_req <= 1'b0;
        exit_req <= 1'b0;
        @(negedge clk);
        while (done !== 1'b1 && fault !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            absent_done <= 1'b0;
            if (absent_req === 1'b1 && ab == 8'h00)
            begin
                ab = absent_seg;
                mm.mem[12'h118][15] = 1'b0;
                absent_done <= 1'b1;
            end
            @(negedge clk);
            n++;
        end
        if (n == 300)
        begin
            chk(1'b0, "no completion");
            report_and_stop();
        end
    endtask

    initial
    begin
        foreach (mm.mem[i]) mm.mem[i] = 16'h0000;
        mm.mem[0] = 16'h0100;
        mm.mem[1] = 16'h0200;
        mm.mem[12'h100] = 16'h0118;
        mm.mem[12'h114] = 16'h0010;
        mm.mem[12'h117] = 16'h0400;
        mm.mem[12'h204] = 16'h0008;
        mm.mem[12'h207] = 16'h0600;
        mm.mem[12'h118] = 16'h8004;
        mm.mem[12'h11B] = 16'h0700;
        mm.mem[12'h43F] = 16'h0003;
        mm.mem[12'h43D] = 16'h0040;
        mm.mem[12'h43E] = 16'hC103;
        mm.mem[12'h43C] = 16'h0601;
        mm.mem[12'h61F] = 16'h0002;
        mm.mem[12'h61E] = 16'h800A;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        saved_status <= 16'h0005;
        saved_ret    <= 16'h0011;
        tos_label    <= 16'h0010;
        slow         <= 1'b1;
        run(1'b1, 7'h00, 1'b0);
        chk(code_base_reg === 16'h0400 && prog_counter === 16'h0411, "exit");
        chk(status_word === 16'h0005, "status");
        chk(code_limit_reg === 16'h043F, "limit");
        chk(mm.mem[12'h114][13] === 1'b1, "ref flag");
        $display("test exit done");
        run(1'b0, 7'h02, 1'b1);
        chk(prog_counter === 16'h0420, "local pc");
        chk(mm.last_waddr[19:8] === 12'h008, "push");
        chk(mm.mem[mm.last_waddr[11:0] - 12'h001] === 16'h0012, "ret addr");
        run(1'b0, 7'h00, 1'b1);
        chk(prog_counter === 16'h0408, "stack label");
        repeat (4)
        begin
            run(1'b0, 7'h04 + 7'($random(seed) & 63), 1'b1);
            chk(fault === 1'b1 && fault_code === CSL_F_STTRNG, "range");
        end
        slow <= 1'b0;
        run(1'b0, 7'h01, 1'b1);
        chk(fault === 1'b1 && fault_code === CSL_F_UNCALL, "uncall");
        run(1'b0, 7'h01, 1'b0);
        chk(code_base_reg === 16'h0600 && prog_counter === 16'h0605, "prog");
        chk(code_limit_reg === 16'h061F && code_bank === 4'h0, "prog lim");
        chk(status_word === 16'h00C1, "prog status");
        $display("test external done");
        run(1'b1, 7'h00, 1'b0);
        run(1'b0, 7'h03, 1'b1);
        chk(ab === 8'h06 && code_base_reg === 16'h0700, "absent");
        chk(prog_counter === 16'h0700, "entry zero");
        @(posedge clk);
        dseg_num <= 8'h00;
        dseg_req <= 1'b1;
        @(posedge clk);
        dseg_num <= 8'h01 + 8'($random(seed) & 127);
        @(negedge clk);
        chk(dseg_fault === 1'b1, "dseg zero");
        @(posedge clk);
        dseg_req <= 1'b0;
        @(negedge clk);
        chk(dseg_fault === 1'b0, "dseg other");
        $display("test dseg done");
        report_and_stop();
    end
endmodule // code_segment_call_linkage_tb
